// *** talrm_pkg.sv ***
package talrm_pkg;

    // register byte offsets on the axi4-lite slave
    localparam logic [7:0] TALRM_OFF_CTRL   = 8'h00;
    localparam logic [7:0] TALRM_OFF_HIGH   = 8'h04;
    localparam logic [7:0] TALRM_OFF_LOW    = 8'h08;
    localparam logic [7:0] TALRM_OFF_HYST   = 8'h0C;
    localparam logic [7:0] TALRM_OFF_CRIT   = 8'h10;
    localparam logic [7:0] TALRM_OFF_STAT   = 8'h14;
    localparam logic [7:0] TALRM_OFF_IRQ    = 8'h18;
    localparam logic [7:0] TALRM_OFF_MASK   = 8'h1C;
    localparam logic [7:0] TALRM_OFF_CMD    = 8'h20;
    localparam logic [7:0] TALRM_OFF_ID     = 8'h24;

    // ctrl field positions
    localparam int TALRM_CTRL_CMPMODE = 0;
    localparam int TALRM_CTRL_POLHIGH = 1;
    localparam int TALRM_CTRL_CRITPOL = 2;
    localparam int TALRM_CTRL_SHDN    = 3;

    // irq status bit positions
    localparam int TALRM_IRQ_ALARM = 0;
    localparam int TALRM_IRQ_CRIT  = 1;
    localparam int TALRM_IRQ_RESET = 2;
    localparam int TALRM_IRQ_W     = 3;

    // reset values; limits and hysteresis are 16-bit two's complement temperature codes
    localparam logic [3:0]  TALRM_CTRL_RST = 4'h0;
    localparam logic [15:0] TALRM_HIGH_RST = 16'h2000;
    localparam logic [15:0] TALRM_LOW_RST  = 16'h0500;
    localparam logic [15:0] TALRM_HYST_RST = 16'h0280;
    localparam logic [15:0] TALRM_CRIT_RST = 16'h4980;
    localparam logic [2:0]  TALRM_MASK_RST = 3'h0;

    localparam logic [7:0] TALRM_CMD_RESET = 8'h2F;

    // arbitrary neutral identification value
    localparam logic [7:0] TALRM_ID_VALUE = 8'hA5;

    localparam int TALRM_CLK_MHZ      = 200;
    localparam int TALRM_RELOAD_US    = 200;
    localparam int TALRM_RELOAD_CYC   = TALRM_RELOAD_US * TALRM_CLK_MHZ;

    typedef enum logic [1:0] {
        TALRM_ST_RUN    = 2'b00,
        TALRM_ST_RELOAD = 2'b01
    } talrm_state_e;

    typedef struct packed {
        logic        valid;
        logic [15:0] temp;
    } talrm_sample_s;

    typedef struct packed {
        logic o;
        logic oe_n;
    } talrm_pin_s;

endpackage : talrm_pkg

// *** talrm_limit.sv ***
`timescale 1ns/1ps
`default_nettype none
// one limit channel: alarm state for one comparison pair
module talrm_limit (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        init,
    input  wire logic        cmp_mode,
    input  wire logic        sample_vld,
    input  wire logic [15:0] temp,
    input  wire logic [15:0] high_lim,
    input  wire logic [15:0] low_lim,
    input  wire logic [15:0] hyst,
    input  wire logic        rd_clear,
    input  wire logic        shdn_enter,
    output logic             active
);
    logic signed [16:0] t_s;
    logic signed [16:0] hi_s;
    logic signed [16:0] lo_s;
    logic signed [16:0] hy_s;
    logic               trip;
    logic               release_ok;
    logic               active_r;

    assign t_s  = {temp[15], temp};
    assign hi_s = {high_lim[15], high_lim};
    assign lo_s = {low_lim[15], low_lim};
    assign hy_s = {hyst[15], hyst};
    assign trip = (t_s > hi_s) || (t_s < lo_s);
    assign release_ok = (t_s < (hi_s - hy_s)) && (t_s > (lo_s + hy_s));
    assign active = active_r;

    always_ff @(posedge aclk) begin
        if (!aresetn || init) begin
            active_r <= 1'b0;
        end else if (cmp_mode) begin
            if (sample_vld && trip) begin
                active_r <= 1'b1;
            end else if (sample_vld && release_ok) begin
                active_r <= 1'b0;
            end
        end else begin
            if (sample_vld && trip) begin
                active_r <= 1'b1;
            end else if (rd_clear || shdn_enter) begin
                active_r <= 1'b0;
            end
        end
    end
endmodule : talrm_limit
`default_nettype wire

// *** talrm_top.sv ***
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - alarm and critical outputs have comparator and interrupt modes; interrupt after reset
// - alarm goes active when temperature is above high or below low limit
// - comparator mode releases below high minus hysteresis and above low plus it
// - comparator mode keeps alarm state when shutdown is entered
// - interrupt mode clears alarm on any register read
// - after that clear, only a new out-of-limit sample sets it, no hysteresis
// - interrupt mode clears alarm when shutdown is entered
// - command 0x2F reloads defaults and ignores the bus for about 200 us
module talrm_top
    import talrm_pkg::*;
#(
    parameter int RELOAD_CYC = talrm_pkg::TALRM_RELOAD_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire talrm_pkg::talrm_sample_s sample,
    input  wire logic        alarm_in,
    input  wire logic        critical_in,
    output var talrm_pkg::talrm_pin_s alarm_pin,
    output var talrm_pkg::talrm_pin_s critical_output,
    output logic             busy,
    output logic             irq
);
    import talrm_pkg::*;

    logic [3:0]         ctrl_r;
    logic [15:0]        high_r;
    logic [15:0]        low_r;
    logic [15:0]        hysteresis_value_r;
    logic [15:0]        crit_r;
    logic [15:0]        temp_r;
    logic [2:0]         irq_r;
    logic [2:0]         mask_r;
    talrm_state_e       state_r;
    logic [31:0]        cnt_r;
    logic               aw_held_r;
    logic               w_held_r;
    logic [7:0]         awaddr_r;
    logic [31:0]        wdata_r;
    logic [3:0]         wstrb_r;
    logic               bvalid_r;
    logic [1:0]         bresp_r;
    logic               rvalid_r;
    logic [31:0]        rdata_r;
    logic [1:0]         rresp_r;
    logic               shdn_d_r;
    logic               alarm_d_r;
    logic               crit_d_r;
    logic               do_write;
    logic               do_read;
    logic               init;
    logic               rd_clear;
    logic               shdn_enter;
    logic               alarm_act;
    logic               crit_act;
    logic               cmd_reset;
    logic               map_ok_w;
    logic [15:0]        wd16;

    // bus traffic stalls while defaults reload
    assign busy          = (state_r == TALRM_ST_RELOAD);
    assign s_axi_awready = !aw_held_r && !busy;
    assign s_axi_wready  = !w_held_r && !busy;
    assign s_axi_arready = !rvalid_r && !busy;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign do_read  = s_axi_arvalid && s_axi_arready;
    assign wd16     = {wstrb_r[1] ? wdata_r[15:8] : 8'h00, wstrb_r[0] ? wdata_r[7:0] : 8'h00};
    assign cmd_reset = do_write && (awaddr_r == TALRM_OFF_CMD) && wstrb_r[0]
                     && (wdata_r[7:0] == TALRM_CMD_RESET);
    assign init      = cmd_reset;
    assign rd_clear  = do_read;
    assign shdn_enter = ctrl_r[TALRM_CTRL_SHDN] && !shdn_d_r;

    always_comb begin
        unique case (awaddr_r)
            TALRM_OFF_CTRL, TALRM_OFF_HIGH, TALRM_OFF_LOW, TALRM_OFF_HYST,
            TALRM_OFF_CRIT, TALRM_OFF_IRQ, TALRM_OFF_MASK, TALRM_OFF_CMD: map_ok_w = 1'b1;
            default: map_ok_w = 1'b0;
        endcase
    end

    // address and data latches, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= 2'b00;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= map_ok_w ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // configuration registers; default reload also from the command
    always_ff @(posedge aclk) begin
        if (!aresetn || init) begin
            ctrl_r             <= TALRM_CTRL_RST;
            high_r             <= TALRM_HIGH_RST;
            low_r              <= TALRM_LOW_RST;
            hysteresis_value_r <= TALRM_HYST_RST;
            crit_r             <= TALRM_CRIT_RST;
            mask_r             <= TALRM_MASK_RST;
        end else if (do_write) begin
            unique case (awaddr_r)
                TALRM_OFF_CTRL: if (wstrb_r[0]) ctrl_r <= wdata_r[3:0];
                TALRM_OFF_HIGH: high_r <= wd16;
                TALRM_OFF_LOW:  low_r  <= wd16;
                TALRM_OFF_HYST: hysteresis_value_r <= wd16;
                TALRM_OFF_CRIT: crit_r <= wd16;
                TALRM_OFF_MASK: if (wstrb_r[0]) mask_r <= wdata_r[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            temp_r   <= 16'h0000;
            shdn_d_r <= 1'b0;
        end else begin
            if (sample.valid) begin
                temp_r <= sample.temp;
            end
            shdn_d_r <= ctrl_r[TALRM_CTRL_SHDN];
        end
    end

    // alarm compares against high/low with hysteresis
    talrm_limit u_alarm (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .init       (init),
        .cmp_mode   (ctrl_r[TALRM_CTRL_CMPMODE]),
        .sample_vld (sample.valid),
        .temp       (sample.temp),
        .high_lim   (high_r),
        .low_lim    (low_r),
        .hyst       (hysteresis_value_r),
        .rd_clear   (rd_clear),
        .shdn_enter (shdn_enter),
        .active     (alarm_act)
    );

    // critical channel: upper limit only, low bound pinned to minimum
    talrm_limit u_crit (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .init       (init),
        .cmp_mode   (ctrl_r[TALRM_CTRL_CMPMODE]),
        .sample_vld (sample.valid),
        .temp       (sample.temp),
        .high_lim   (crit_r),
        .low_lim    (16'h8000),
        .hyst       (hysteresis_value_r),
        .rd_clear   (rd_clear),
        .shdn_enter (shdn_enter),
        .active     (crit_act)
    );

    // open drain: enable low while pulling; inactive level released high, or pulled low when the polarity bit is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_pin       <= '{o: 1'b0, oe_n: 1'b1};
            critical_output <= '{o: 1'b0, oe_n: 1'b1};
        end else begin
            alarm_pin.o          <= 1'b0;
            alarm_pin.oe_n       <= ~(alarm_act ^ ctrl_r[TALRM_CTRL_POLHIGH]);
            critical_output.o    <= 1'b0;
            critical_output.oe_n <= ~(crit_act ^ ctrl_r[TALRM_CTRL_CRITPOL]);
        end
    end

    // sticky events, write one to clear; set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r     <= 3'h0;
            alarm_d_r <= 1'b0;
            crit_d_r  <= 1'b0;
        end else begin
            alarm_d_r <= alarm_act;
            crit_d_r  <= crit_act;
            irq_r <= (irq_r & ~((do_write && awaddr_r == TALRM_OFF_IRQ && wstrb_r[0])
                               ? wdata_r[TALRM_IRQ_W-1:0] : 3'h0))
                   | {cmd_reset, crit_act && !crit_d_r, alarm_act && !alarm_d_r};
        end
    end

    assign irq = |(irq_r & mask_r);

    // reload timer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= TALRM_ST_RUN;
            cnt_r   <= 32'h0000_0000;
        end else begin
            unique case (state_r)
                TALRM_ST_RUN: begin
                    if (cmd_reset) begin
                        state_r <= TALRM_ST_RELOAD;
                        cnt_r   <= 32'(RELOAD_CYC - 1);
                    end
                end
                TALRM_ST_RELOAD: begin
                    if (cnt_r == 32'h0000_0000) begin
                        state_r <= TALRM_ST_RUN;
                    end else begin
                        cnt_r <= cnt_r - 32'h0000_0001;
                    end
                end
                default: state_r <= TALRM_ST_RUN;
            endcase
        end
    end

    // read data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= 2'b00;
        end else if (do_read) begin
            rvalid_r <= 1'b1;
            rresp_r  <= 2'b00;
            unique case (s_axi_araddr)
                TALRM_OFF_CTRL: rdata_r <= {28'h000_0000, ctrl_r};
                TALRM_OFF_HIGH: rdata_r <= {16'h0000, high_r};
                TALRM_OFF_LOW:  rdata_r <= {16'h0000, low_r};
                TALRM_OFF_HYST: rdata_r <= {16'h0000, hysteresis_value_r};
                TALRM_OFF_CRIT: rdata_r <= {16'h0000, crit_r};
                TALRM_OFF_STAT: rdata_r <= {16'h0000, crit_act, alarm_act,
                                            alarm_in, critical_in, 12'h000};
                TALRM_OFF_IRQ:  rdata_r <= {29'h0000_0000, irq_r};
                TALRM_OFF_MASK: rdata_r <= {29'h0000_0000, mask_r};
                TALRM_OFF_CMD:  rdata_r <= {16'h0000, temp_r};
                TALRM_OFF_ID:   rdata_r <= {24'h00_0000, TALRM_ID_VALUE};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule : talrm_top
`default_nettype wire

// *** talrm_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module talrm_asserts
    import talrm_pkg::*;
#(
    parameter int RELOAD_CYC = 20
) (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic [7:0]              s_axi_awaddr,
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic [31:0]             s_axi_wdata,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic [1:0]              s_axi_bresp,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire talrm_pkg::talrm_sample_s sample,
    input wire talrm_pkg::talrm_pin_s    alarm_pin,
    input wire talrm_pkg::talrm_pin_s    critical_output,
    input wire logic                    busy
);
    localparam int HI = TALRM_HIGH_RST;
    localparam int LO = TALRM_LOW_RST;
    localparam int HY = TALRM_HYST_RST;
    logic [7:0]        aw_r;
    logic [31:0]       wd_r;
    logic [3:0]        ctl_r;
    logic [31:0]       bcnt_r;
    wire signed [15:0] t   = sample.temp;
    wire               act = alarm_pin.oe_n == ctl_r[TALRM_CTRL_POLHIGH];
    wire               cmp = ctl_r[TALRM_CTRL_CMPMODE];
    wire               run = sample.valid && !ctl_r[TALRM_CTRL_SHDN] && !busy;
    // shadow of the control register, committed at the write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_r <= TALRM_CTRL_RST;
        end else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b00) begin
            if (aw_r == TALRM_OFF_CTRL) ctl_r <= wd_r[3:0];
            if (aw_r == TALRM_OFF_CMD && wd_r[7:0] == TALRM_CMD_RESET) ctl_r <= TALRM_CTRL_RST;
        end
    end
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata;
        bcnt_r <= busy ? bcnt_r + 1 : '0;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_idle: assert property ($rose(aresetn) |-> alarm_pin.oe_n && critical_output.oe_n && !busy)
        else $error("pins or busy wrong after reset");
    a_open_drain: assert property (alarm_pin.o == 1'b0 && critical_output.o == 1'b0)
        else $error("open drain pin drives high");
    a_busy_refuse: assert property (busy |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("bus taken while reloading");
    a_busy_span: assert property ($fell(busy) |-> bcnt_r == RELOAD_CYC)
        else $error("reload window length wrong");
    a_trip_out: assert property (run && (t > HI || t < LO) |-> ##2 act)
        else $error("alarm not raised on limit trip");
    a_cmp_release: assert property (run && cmp && t < HI - HY && t > LO + HY |-> ##2 !act)
        else $error("comparator alarm not released");
    a_read_clear: assert property (!cmp && s_axi_arvalid && s_axi_arready && !sample.valid
        |-> ##2 !act)
        else $error("read did not clear alarm");
    a_int_shdn: assert property ($rose(ctl_r[TALRM_CTRL_SHDN]) && !cmp |-> ##[0:2] !act)
        else $error("shutdown did not clear alarm");
    a_cmp_shdn: assert property ($rose(ctl_r[TALRM_CTRL_SHDN]) && cmp
        |-> $stable(alarm_pin.oe_n)[*3])
        else $error("shutdown changed comparator alarm");
    cover property (run && t > HI);
    cover property ($rose(busy));
    cover property (!cmp && s_axi_arvalid && s_axi_arready && act);
endmodule : talrm_asserts
bind talrm_top talrm_asserts #(.RELOAD_CYC(RELOAD_CYC)) u_chk (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .sample, .alarm_pin, .critical_output, .busy
);
`default_nettype wire

// *** talrm_far.sv ***
`timescale 1ns/1ps
`default_nettype none
module talrm_far
    import talrm_pkg::*;
(
    input  wire talrm_pkg::talrm_pin_s alarm_pin,
    input  wire talrm_pkg::talrm_pin_s critical_output,
    output logic                       alarm_line,
    output logic                       crit_line
);
    // pull-up resistors win unless the pin pulls low
    assign alarm_line = alarm_pin.oe_n ? 1'b1 : alarm_pin.o;
    assign crit_line  = critical_output.oe_n ? 1'b1 : critical_output.o;
endmodule : talrm_far
`default_nettype wire

// *** test_temperature_alarm_output_logic.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_temperature_alarm_output_logic;
    import talrm_pkg::*;
    logic          aclk, aresetn, pol, a_line, c_line, busy, irq;
    logic          s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]    s_axi_awaddr, s_axi_araddr;
    logic [31:0]   s_axi_wdata, s_axi_rdata;
    logic [3:0]    s_axi_wstrb;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    talrm_sample_s sample;
    talrm_pin_s    alarm_pin, critical_output;
    logic [33:0]   rq[$];
    logic [1:0]    bq[$];
    int            err_count, checks_done;
    int            seed = 32'h4fe1_0e6d;
    talrm_top #(.RELOAD_CYC(20)) i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample, .alarm_in(a_line),
        .critical_in(c_line), .alarm_pin, .critical_output, .busy, .irq
    );
    talrm_far i_far (.alarm_pin, .critical_output, .alarm_line(a_line), .crit_line(c_line));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic check_bus(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bus
    task automatic check_sig(input logic got, input logic exp);
        check_bus({33'h0, got}, {33'h0, exp});
    endtask : check_sig
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) check_bus({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (s_axi_rvalid && s_axi_rready) check_bus({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'b00);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        bq.push_back(e);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            aw_ok = aw_ok || s_axi_awready;
            w_ok  = w_ok || s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid  <= !w_ok;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'b00);
        rq.push_back({e, d});
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic smp(input logic [15:0] t);
        @(posedge aclk);
        sample <= '{valid: 1'b1, temp: t};
        @(posedge aclk);
        sample.valid <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : smp
    // alarm line level expected for the current polarity
    task automatic pin(input logic act);
        repeat (3) @(posedge aclk);
        #1 check_sig(a_line, act ? pol : !pol);
    endtask : pin
    task automatic done(input string s);
        $display("%s done", s);
    endtask : done
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (6000) @(posedge aclk);
        err_count++;
        close_out();
    end
    initial begin
        {aresetn, pol, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        sample = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(TALRM_OFF_CTRL, 32'h0);
        rd(TALRM_OFF_ID, {24'h0, TALRM_ID_VALUE});
        rd(8'h30, 32'h0, 2'b10);
        wr(8'h30, 32'h0, 2'b10);
        pin(1'b0);
        done("reset");
        smp(16'h2100);
        pin(1'b1);
        smp(16'h0800 + (16'($random(seed)) & 16'h0FFF));
        pin(1'b1);
        rd(TALRM_OFF_MASK, 32'h0);
        pin(1'b0);
        smp(16'h1F00);
        pin(1'b0);
        smp(16'h0400);
        pin(1'b1);
        check_sig(irq, 1'b0);
        wr(TALRM_OFF_MASK, 32'h1);
        #1 check_sig(irq, 1'b1);
        wr(TALRM_OFF_IRQ, 32'h1);
        #1 check_sig(irq, 1'b0);
        wr(TALRM_OFF_CTRL, 32'h8);
        pin(1'b0);
        wr(TALRM_OFF_CTRL, 32'h0);
        done("interrupt mode");
        wr(TALRM_OFF_CTRL, 32'h3);
        pol = 1'b1;
        pin(1'b0);
        smp(16'h2100);
        rd(TALRM_OFF_CTRL, 32'h3);
        pin(1'b1);
        rd(TALRM_OFF_STAT, 32'h0000_7000);
        smp(16'h1F00);
        pin(1'b1);
        wr(TALRM_OFF_CTRL, 32'hB);
        pin(1'b1);
        wr(TALRM_OFF_CTRL, 32'h3);
        smp(16'h1000);
        pin(1'b0);
        smp(16'h0400);
        smp(16'h0600);
        pin(1'b1);
        smp(16'h0800);
        pin(1'b0);
        smp(16'h4A00);
        check_sig(c_line, 1'b0);
        done("comparator mode");
        wr(TALRM_OFF_CMD, {24'h0, TALRM_CMD_RESET});
        pol = 1'b0;
        #1 check_sig(busy, 1'b1);
        rd(TALRM_OFF_CTRL, 32'h0);
        check_sig(busy, 1'b0);
        smp(16'h2100);
        rd(TALRM_OFF_CTRL, 32'h0);
        pin(1'b0);
        done("reload");
        close_out();
    end
endmodule : test_temperature_alarm_output_logic
`default_nettype wire
